/* File: scfc_pkg.sv */
/*
 * constants, field positions and encodings shared by the stepper chopper
 * and fault control block.
 * assumes a 50 MHz pclk and an APB master with 32-bit data and byte addresses.
 */
package scfc_pkg;

   // ----------------------------------------
   // clock, oscillator and timing
   // ----------------------------------------
   localparam int CLK_HZ = 50_000_000;
   localparam int CLK_PERIOD_NS = 20;
   localparam int OSC_HZ = 4_000_000;
   localparam int ACC_STEP_HZ = 2_000_000;
   localparam logic [4:0] ACC_INC = 5'(OSC_HZ / ACC_STEP_HZ);
   localparam logic [4:0] ACC_MOD = 5'(CLK_HZ / ACC_STEP_HZ);
   localparam int OFF_DEF_US = 25;
   localparam int OFF_DEF_TICKS = OFF_DEF_US * (OSC_HZ / 1_000_000);
   localparam int BLANK_NS = 1000;
   localparam int BLANK_CYC = BLANK_NS / CLK_PERIOD_NS;
   localparam int BLANK_W = 6;
   localparam int FD_PERMILLE = 301;
   localparam int PERMILLE = 1000;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] ADDR_OFFTIME = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam int ST_SHORT_LSB = 0;
   localparam int ST_REG_FAULT = 2;
   localparam int ST_PUMP_UV = 3;
   localparam int ST_OVER_TEMP = 4;
   localparam int ST_LOCKOUT = 5;
   localparam int ST_DISABLED = 6;
   localparam int ST_MIXED_LSB = 8;
   localparam int ST_POS_LSB = 16;

   // ----------------------------------------
   // pin input vector positions
   // ----------------------------------------
   localparam int IN_STEP = 0;
   localparam int IN_DIR = 1;
   localparam int IN_RES_LSB = 2;
   localparam int IN_ENABLE_N = 4;
   localparam int IN_SLEEP_N = 5;
   localparam int IN_STRAP_GND = 6;
   localparam int IN_REG_FAULT = 7;
   localparam int IN_PUMP_UV = 8;
   localparam int IN_OVER_TEMP = 9;
   localparam int IN_LOCKOUT = 10;
   localparam int IN_TRIP_LSB = 11;
   localparam int IN_OC_LSB = 13;
   localparam int IN_ZERO_LSB = 15;
   localparam int NIN = 17;

   // ----------------------------------------
   // translator
   // ----------------------------------------
   localparam logic [5:0] HOME_POS = 6'h00;
   localparam logic [1:0] MIXED_HOME = 2'b11;
   localparam logic [5:0] STEP_FULL = 6'h10;
   localparam logic [5:0] STEP_HALF = 6'h08;
   localparam logic [5:0] STEP_QUARTER = 6'h04;
   localparam logic [5:0] STEP_SIXTEENTH = 6'h01;

   typedef enum logic [1:0] {BR_ON, BR_FAST, BR_SLOW} scfc_br_type;

endpackage

/* File: scfc_top.sv */
/*
 * stepper chopper and fault control: translator, two fixed off-time chopping
 * bridges with blanking, slow/mixed decay with synchronous rectification,
 * output enable and fault shutdown, APB register slave.
 * assumes all pin inputs are asynchronous to pclk; gate outputs feed the
 * bridge pre-drivers; the APB master follows the usual two-phase protocol.
 */
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps

module scfc_top #(
   parameter int OFF_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic advance_pulse,
   input wire logic rotation_direction_input,
   input wire logic [1:0] resolution_select_bits,
   input wire logic enable_n,
   input wire logic low_power_clear_input_n,
   input wire logic offtime_resistor_pin_gnd,
   input wire logic internal_regulator_rail_fault,
   input wire logic gate_pump_reservoir_uv,
   input wire logic over_temp,
   input wire logic undervoltage_lockout,
   input wire logic [1:0] current_trip_level_hit,
   input wire logic [1:0] short_current_hit,
   input wire logic [1:0] zero_current_seen,
   output logic [7:0] bridge_gates
);
   import scfc_pkg::*;

   // ----------------------------------------
   // parameter check
   // ----------------------------------------
   if (OFF_W < 7 || OFF_W > 20) begin : g_bad_off_w
      $error("OFF_W must hold the default off-time count and stay below 21 bits");
   end

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [NIN-1:0] s1;
      logic [NIN-1:0] s2;
      logic step_d;
      logic [5:0] pos;
      logic [1:0] mixed;
      scfc_br_type [1:0] st;
      logic [1:0][BLANK_W-1:0] blank;
      logic [1:0][OFF_W-1:0] offc;
      logic [1:0] sr_off;
      logic [1:0] short_lat;
      logic [4:0] acc;
      logic tick;
      logic dis;
      logic [OFF_W-1:0] off_cfg;
      logic [7:0] gates;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } scfc_state_type;

   scfc_state_type r;
   scfc_state_type n;
   logic [NIN-1:0] pins_in;
   logic step_rise;
   logic awake;
   logic dis_now;
   logic setup;
   logic access;
   logic addr_ok;
   logic [5:0] stp;
   logic [5:0] npos;
   logic [OFF_W-1:0] off_len;
   logic [OFF_W-1:0] fd_len;
   logic [OFF_W-1:0] offc_inc;
   logic [5:0] acc_sum;
   logic [31:0] rd;
   logic bpol;

   assign pins_in = {zero_current_seen, short_current_hit, current_trip_level_hit, undervoltage_lockout,
                     over_temp, gate_pump_reservoir_uv, internal_regulator_rail_fault,
                     offtime_resistor_pin_gnd, low_power_clear_input_n, enable_n,
                     resolution_select_bits, rotation_direction_input, advance_pulse};

   // stand-in quantised level: triangle repeating every 32 positions of the 64-position cycle
   function automatic logic [4:0] lvl(input logic [5:0] p);
      lvl = p[4] ? {1'b0, p[3:0]} : 5'h10 - {1'b0, p[3:0]};
   endfunction

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      n = r;
      n.s1 = pins_in;
      n.s2 = r.s1;
      awake = r.s2[IN_SLEEP_N];
      step_rise = r.s2[IN_STEP] & ~r.step_d;
      n.step_d = r.s2[IN_STEP];
      stp = STEP_FULL;
      npos = r.pos;
      bpol = 1'b0;

      // 4 MHz tick from 50 MHz by a fractional accumulator: 2 ticks per 25 clocks
      acc_sum = {1'b0, r.acc} + {1'b0, ACC_INC};
      n.tick = 1'b0;
      if (acc_sum >= {1'b0, ACC_MOD}) begin
         n.acc = 5'(acc_sum - {1'b0, ACC_MOD});
         n.tick = 1'b1;
      end else begin
         n.acc = acc_sum[4:0];
      end

      // translator
      if (r.s2[IN_LOCKOUT] | ~awake) begin
         n.pos = HOME_POS;
         n.mixed = MIXED_HOME;
      end else if (step_rise) begin
         unique case (r.s2[IN_RES_LSB +: 2])
            2'b00: stp = STEP_FULL;
            2'b01: stp = STEP_HALF;
            2'b10: stp = STEP_QUARTER;
            2'b11: stp = STEP_SIXTEENTH;
         endcase
         npos = r.s2[IN_DIR] ? r.pos + stp : r.pos - stp;
         n.pos = npos;
         n.mixed[0] = lvl(npos) < lvl(r.pos);
         n.mixed[1] = lvl(6'(npos + 6'h10)) < lvl(6'(r.pos + 6'h10));
      end

      // short-to-ground latch; sense overcurrent never reaches it
      // set wins over the sleep clear: a short seen as sleep falls is kept one cycle,
      // then the sleep clear takes it because the outputs are already off
      if (~awake) begin
         n.short_lat = 2'b00;
      end
      for (int b = 0; b < 2; b++) begin
         if (r.s2[IN_OC_LSB + b] & ~r.dis) begin
            n.short_lat[b] = 1'b1;
         end
      end

      dis_now = r.s2[IN_ENABLE_N] | r.s2[IN_REG_FAULT] | r.s2[IN_PUMP_UV] | r.s2[IN_OVER_TEMP]
                | r.s2[IN_LOCKOUT] | ~awake | (|n.short_lat);
      n.dis = dis_now;

      off_len = r.s2[IN_STRAP_GND] ? OFF_W'(OFF_DEF_TICKS) : r.off_cfg;
      fd_len = OFF_W'((32'(off_len) * FD_PERMILLE) / PERMILLE);

      // chopper per bridge
      for (int b = 0; b < 2; b++) begin
         offc_inc = r.offc[b] + OFF_W'(1);
         if (dis_now) begin
            n.st[b] = BR_ON;
            n.blank[b] = BLANK_W'(BLANK_CYC);
            n.offc[b] = '0;
            n.sr_off[b] = 1'b0;
         end else begin
            unique case (r.st[b])
               BR_ON: begin
                  if (r.blank[b] != '0) begin
                     n.blank[b] = r.blank[b] - BLANK_W'(1);
                  end else if (r.s2[IN_TRIP_LSB + b]) begin
                     n.st[b] = r.mixed[b] ? BR_FAST : BR_SLOW;
                     n.blank[b] = BLANK_W'(BLANK_CYC);
                     n.offc[b] = '0;
                     n.sr_off[b] = 1'b0;
                  end
               end
               BR_FAST, BR_SLOW: begin
                  if (r.s2[IN_ZERO_LSB + b]) begin
                     n.sr_off[b] = 1'b1;
                  end
                  if (r.blank[b] != '0) begin
                     n.blank[b] = r.blank[b] - BLANK_W'(1);
                  end
                  if (r.tick) begin
                     n.offc[b] = offc_inc;
                     if (offc_inc >= off_len) begin
                        n.st[b] = BR_ON;
                        n.blank[b] = BLANK_W'(BLANK_CYC);
                        n.offc[b] = '0;
                        n.sr_off[b] = 1'b0;
                     end else if (r.st[b] == BR_FAST && offc_inc >= fd_len) begin
                        n.st[b] = BR_SLOW;
                        n.blank[b] = BLANK_W'(BLANK_CYC);
                     end
                  end
               end
            endcase
         end
      end

      // gate pattern per bridge: {src_a, snk_a, src_b, snk_b}
      // polarity follows the new position, so gates and translator move on one edge
      for (int b = 0; b < 2; b++) begin
         bpol = (b == 0) ? ~(n.pos[5] ^ n.pos[4]) : ~n.pos[5];
         if (dis_now) begin
            n.gates[4*b +: 4] = 4'h0;
         end else begin
            unique case (n.st[b])
               BR_ON: n.gates[4*b +: 4] = bpol ? 4'h9 : 4'h6;
               BR_FAST: n.gates[4*b +: 4] = n.sr_off[b] ? 4'h0 : (bpol ? 4'h6 : 4'h9);
               BR_SLOW: n.gates[4*b +: 4] = n.sr_off[b] ? 4'h0 : 4'h5;
            endcase
         end
      end

      // APB slave: zero wait states, answer in the first access cycle
      setup = psel & ~penable;
      access = psel & penable & r.pready;
      addr_ok = (paddr == ADDR_OFFTIME) | (paddr == ADDR_STATUS);
      rd = 32'h0000_0000;
      if (paddr == ADDR_OFFTIME) begin
         rd[OFF_W-1:0] = r.off_cfg;
      end else if (paddr == ADDR_STATUS) begin
         rd[ST_SHORT_LSB +: 2] = r.short_lat;
         rd[ST_REG_FAULT] = r.s2[IN_REG_FAULT];
         rd[ST_PUMP_UV] = r.s2[IN_PUMP_UV];
         rd[ST_OVER_TEMP] = r.s2[IN_OVER_TEMP];
         rd[ST_LOCKOUT] = r.s2[IN_LOCKOUT];
         rd[ST_DISABLED] = r.dis;
         rd[ST_MIXED_LSB +: 2] = r.mixed;
         rd[ST_POS_LSB +: 6] = r.pos;
      end
      n.pready = setup;
      n.pslverr = setup & ~addr_ok;
      n.prdata = setup ? rd : 32'h0000_0000;
      if (access & pwrite & (paddr == ADDR_OFFTIME)) begin
         n.off_cfg = pwdata[OFF_W-1:0];
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.mixed <= MIXED_HOME;
         r.dis <= 1'b1;
         r.off_cfg <= OFF_W'(OFF_DEF_TICKS);
      end else begin
         r <= n;
      end
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign bridge_gates = r.gates;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_pos_on_step: assert property (
      (r.pos != n.pos) |-> (step_rise || r.s2[IN_LOCKOUT] || !awake))
      else $error("translator moved without a step edge");

   a_dir_step_size: assert property (
      (step_rise && awake && !r.s2[IN_LOCKOUT] && r.s2[IN_DIR] && r.s2[IN_RES_LSB +: 2] == 2'b11)
      |=> r.pos == 6'($past(r.pos) + 6'h01))
      else $error("sixteenth step forward did not advance by one");

   a_disabled_off: assert property (
      (r.s2[IN_ENABLE_N] || r.s2[IN_REG_FAULT] || r.s2[IN_OVER_TEMP]) |=> r.gates == 8'h00)
      else $error("gates driven while disabled");

   a_on_diagonal: assert property (
      (r.st[0] == BR_ON && !r.dis) |-> (r.gates[3:0] == 4'h9 || r.gates[3:0] == 4'h6))
      else $error("on-period is not a diagonal pair");

   a_slow_src_off: assert property (
      (r.st[0] == BR_SLOW && !r.dis) |-> (r.gates[3] == 1'b0 && r.gates[1] == 1'b0))
      else $error("source on during slow decay");

   a_blank_hold: assert property (
      (r.st[1] == BR_ON && r.blank[1] != '0 && !dis_now) |=> r.st[1] == BR_ON)
      else $error("trip accepted inside blanking");

   a_mixed_fast: assert property (
      (r.st[0] == BR_ON && r.blank[0] == '0 && r.s2[IN_TRIP_LSB] && r.mixed[0] && !dis_now)
      |=> r.st[0] == BR_FAST ##1 r.st[0] == BR_FAST)
      else $error("mixed decay did not start fast");

   a_short_latch: assert property (
      (r.s2[IN_OC_LSB] && !r.dis && awake) |=> r.short_lat[0] && r.gates == 8'h00)
      else $error("short not latched or outputs still on");

   a_short_hold: assert property (
      (r.short_lat != 2'b00 && r.s1[IN_SLEEP_N] && awake) |=> r.short_lat != 2'b00)
      else $error("short latch released while awake");

   a_lockout_home: assert property (
      r.s2[IN_LOCKOUT] |=> (r.pos == HOME_POS && r.mixed == MIXED_HOME && r.gates == 8'h00))
      else $error("lockout did not home the translator");

   c_trip_slow: cover property (r.st[0] == BR_ON ##1 r.st[0] == BR_SLOW);
   c_fast_to_slow: cover property (r.st[1] == BR_FAST ##1 r.st[1] == BR_SLOW);
   c_short: cover property (!r.short_lat[1] ##1 r.short_lat[1]);
   c_apb_write: cover property (access && pwrite && paddr == ADDR_OFFTIME);
   c_zero_cut: cover property (!r.sr_off[0] ##1 r.sr_off[0]);

endmodule

/* File: scfc_winding_model.sv */
/*
 * behavioural winding and sense model for both bridges of the stepper chopper.
 * assumes bridge_gates nibbles {src_a,snk_a,src_b,snk_b} and one pclk domain.
 */
`timescale 1ns/1ps
module scfc_winding_model #(
   parameter int LIM = 200
) (
   input wire logic pclk,
   input wire logic [7:0] bridge_gates,
   input wire logic load_short,
   input wire logic [1:0] gnd_short,
   output logic [1:0] trip,
   output logic [1:0] over,
   output logic [1:0] zero
);
   // ----------------------------------------
   // current ramps one unit a cycle: crude, but trip and zero come in order
   // ----------------------------------------
   int cur [2] = '{0, 0};
   logic [3:0] g;
   always @(posedge pclk) begin
      for (int b = 0; b < 2; b++) begin
         g = bridge_gates[4*b+:4];
         // signed winding current: each diagonal pushes its own way, so fast decay
         // (the opposite diagonal) pulls the current toward zero and past it
         if (g == 4'h9) begin
            cur[b] <= (cur[b] < LIM) ? cur[b] + 1 : cur[b];
         end else if (g == 4'h6) begin
            cur[b] <= (cur[b] > -LIM) ? cur[b] - 1 : cur[b];
         end else begin
            cur[b] <= (cur[b] > 0) ? cur[b] - 1 : ((cur[b] < 0) ? cur[b] + 1 : 0);
         end
         // a shorted load shows through the sense resistor, so the comparator stays tripped
         trip[b] <= load_short || (cur[b] >= LIM) || (cur[b] <= -LIM);
         over[b] <= gnd_short[b] && ((g == 4'h9) || (g == 4'h6));
         zero[b] <= (cur[b] == 0);
      end
   end
endmodule

/* File: tb_top.sv */
/*
 * self-checking bench for the stepper chopper and fault control block.
 * assumes the winding model on the bridge side and an APB master here.
 */
`timescale 1ns/1ps
module tb_top;
   import scfc_pkg::*;
   typedef struct {logic [31:0] d; logic [31:0] m; logic er;} scfc_exp_type;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, bridge_gates;
   logic [31:0] pwdata, prdata;
   logic advance_pulse, rotation_direction_input, enable_n, sleep_n, strap, load_short;
   logic [1:0] resolution_select_bits, trip, over, zero, gnd_short, mix, sl, mm;
   logic [3:0] flt, f1, onp;
   logic [5:0] pos;
   scfc_exp_type q[$];
   scfc_exp_type e;
   int err_count = 0;
   int num_checks = 0;
   int off, nf, no, non;
   bit z;

   scfc_top #(.OFF_W(12)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .advance_pulse(advance_pulse), .rotation_direction_input(rotation_direction_input),
      .resolution_select_bits(resolution_select_bits), .enable_n(enable_n),
      .low_power_clear_input_n(sleep_n), .offtime_resistor_pin_gnd(strap),
      .internal_regulator_rail_fault(flt[0]), .gate_pump_reservoir_uv(flt[1]), .over_temp(flt[2]),
      .undervoltage_lockout(flt[3]), .current_trip_level_hit(trip), .short_current_hit(over),
      .zero_current_seen(zero), .bridge_gates(bridge_gates));
   scfc_winding_model #(.LIM(200)) wm (.pclk(pclk), .bridge_gates(bridge_gates), .load_short(load_short),
      .gnd_short(gnd_short), .trip(trip), .over(over), .zero(zero));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // ----------------------------------------
   // checking helpers
   // ----------------------------------------
   task cmp(input logic [31:0] g, input logic [31:0] x);
      num_checks++;
      if (g !== x) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic rng(input int v, input int lo, input int hi);
      cmp(32'(v), 32'((v < lo) ? lo : ((v > hi) ? hi : v)));
   endtask
   task give_verdict;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   function automatic logic [3:0] gb(input int b);
      return bridge_gates[4*b+:4];
   endfunction
   function automatic logic [3:0] pol(input int b);
      return ((b == 0) ? (pos[5] == pos[4]) : !pos[5]) ? 4'h9 : 4'h6;
   endfunction
   function automatic logic [4:0] lvl(input logic [5:0] p);
      return p[4] ? {1'b0, p[3:0]} : 5'h10 - {1'b0, p[3:0]};
   endfunction
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && q.size() > 0) begin
         e = q.pop_front();
         cmp(32'(pslverr), 32'(e.er));
         cmp(prdata & e.m, e.d & e.m);
      end
   end
   initial begin
      // the sequence needs about 60,000 cycles, most of it the wake-up wait
      repeat (90000) @(posedge pclk);
      err_count++;
      give_verdict;
   end

   // ----------------------------------------
   // drivers
   // ----------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] ex,
                      input logic [31:0] m, input logic er);
      int k;
      q.push_back('{ex, m, er});
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) cmp(32'(k), 32'h0);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task rd_st;
      apb(1'b0, ADDR_STATUS, 32'h0, {10'h0, pos, 6'h0, mix, 2'h0, flt, sl}, 32'hFFFF_FCBF | {22'h0, mm, 8'h0}, 1'b0);
   endtask
   task automatic step(input logic d, input logic [1:0] r);
      logic [5:0] np, inc;
      inc = (r == 0) ? STEP_FULL : (r == 1) ? STEP_HALF : (r == 2) ? STEP_QUARTER : STEP_SIXTEENTH;
      rotation_direction_input <= d;
      resolution_select_bits <= r;
      advance_pulse <= 1'b1;
      repeat (4) @(posedge pclk);
      // direction flips between steps must not move anything
      rotation_direction_input <= ~d;
      advance_pulse <= 1'b0;
      repeat (4) @(posedge pclk);
      if (sleep_n && !flt[3]) begin
         np = d ? pos + inc : pos - inc;
         for (int b = 0; b < 2; b++) mix[b] = lvl(np + 6'(16 * b)) < lvl(pos + 6'(16 * b));
         pos = np;
      end
   endtask
   task automatic chop(input int b);
      int k;
      k = 0;
      nf = 0;
      no = 0;
      non = 0;
      z = 0;
      // let a running on or fast-decay diagonal pass, so onp is a real on pair
      while ((gb(b) inside {4'h9, 4'h6}) && k < 3000) begin
         @(negedge pclk);
         k++;
      end
      while (!(gb(b) inside {4'h9, 4'h6}) && k < 3000) begin
         @(negedge pclk);
         k++;
      end
      onp = gb(b);
      while (gb(b) == onp && k < 6000) begin
         @(negedge pclk);
         k++;
         non++;
      end
      f1 = gb(b);
      while (gb(b) != onp && k < 6000) begin
         nf += int'(gb(b) == ~onp);
         z |= (gb(b) == 4'h0);
         no++;
         @(negedge pclk);
         k++;
      end
      if (k >= 6000) cmp(32'(k), 32'h0);
      @(posedge pclk);
   endtask
   task automatic chk(input int b, input bit fast_chk);
      chop(b);
      cmp(32'(onp), 32'(pol(b)));
      cmp(32'(f1), mix[b] ? {28'h0, ~onp} : 32'h5);
      rng(no, off * 25 / 2 - 15, off * 25 / 2 + 15);
      if (fast_chk && mix[b]) rng(nf, (off * 301 / 1000) * 25 / 2 - 15, (off * 301 / 1000) * 25 / 2 + 15);
   endtask
   task gchk(input logic [7:0] x);
      @(negedge pclk);
      cmp(32'(bridge_gates), 32'(x));
      @(posedge pclk);
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, advance_pulse, rotation_direction_input} = '0;
      {resolution_select_bits, enable_n, strap, load_short, gnd_short, flt} = '0;
      sleep_n = 1'b1;
      pos = 6'h0;
      mix = 2'h3;
      mm = 2'h3;
      sl = 2'h0;
      void'($urandom(32'h9D60_8205));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd_st;
      apb(1'b0, ADDR_OFFTIME, 32'h0, 32'h64, 32'hFFFF_FFFF, 1'b0);
      apb(1'b1, 8'h0C, 32'h5A, 32'h0, 32'h0, 1'b1);
      apb(1'b0, 8'h0C, 32'h0, 32'h0, 32'hFFFF_FFFF, 1'b1);
      apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF, 32'h0, 32'h0, 1'b0);
      rd_st;
      strap <= 1'b1;
      off = OFF_DEF_TICKS;
      chk(0, 1'b0);
      cmp(32'(z), 32'h1);
      strap <= 1'b0;
      off = 8 + int'($urandom % 8);
      apb(1'b1, ADDR_OFFTIME, 32'(off), 32'h0, 32'h0, 1'b0);
      apb(1'b0, ADDR_OFFTIME, 32'h0, 32'(off), 32'hFFFF_FFFF, 1'b0);
      chk(0, 1'b1);
      step(1'b1, 2'h0);
      rd_st;
      chk(1, 1'b1);
      chk(0, 1'b1);
      for (int i = 0; i < 8; i++) begin
         step(1'($urandom % 2), 2'(i % 4));
         rd_st;
      end
      load_short <= 1'b1;
      chop(0);
      chk(0, 1'b1);
      rng(non, 50, 56);
      load_short <= 1'b0;
      rd_st;
      enable_n <= 1'b1;
      repeat (4) @(posedge pclk);
      gchk(8'h0);
      step(1'b1, 2'h3);
      rd_st;
      enable_n <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         flt <= 4'h1 << k;
         repeat (4) @(posedge pclk);
         gchk(8'h0);
         if (k == 3) begin
            pos = HOME_POS;
            mix = 2'h3;
         end
         rd_st;
         flt <= 4'h0;
         chop(0);
      end
      gnd_short <= 2'h1;
      repeat (300) @(posedge pclk);
      gnd_short <= 2'h0;
      sl = 2'h1;
      repeat (20) @(posedge pclk);
      gchk(8'h0);
      rd_st;
      sleep_n <= 1'b0;
      repeat (4) @(posedge pclk);
      step(1'b1, 2'h0);
      {sl, pos, mix, mm} = {2'h0, HOME_POS, 2'h3, 2'h3};
      rd_st;
      gchk(8'h0);
      sleep_n <= 1'b1;
      // regulator settle time after leaving sleep, before any step
      repeat (50000) @(posedge pclk);
      chop(0);
      cmp(32'(onp), 32'(pol(0)));
      give_verdict;
   end
endmodule
